// file: rtl/cis_seq.sv
// cis_seq: interrupt gating, priority, entry and return sequencing
// assumes: cpu sequencer gives instruction boundary and instruction
// strobes; peripheral events are pins and pass two flip-flops
`timescale 1ns/1ps
// What this block does
// RULE1 - core logic runs straight on the source clock, no divider inside
// RULE2 - two-operand alu op completes in one cycle; sequencer never stalls it
// RULE3 - every source and reset own a vector; lowest vector wins
// RULE4 - reset ranks first, external_irq_zero right below it
// RULE5 - source taken only with own enable and global enable both set
// RULE6 - vector_relocate_select moves vectors, boot_reset_fuse moves reset vector to boot
// RULE7 - programmed boot lock bits suppress interrupts by program counter region
// RULE8 - accepting an interrupt clears global enable
// RULE9 - software may set global enable inside handler, allowing nesting
// RULE10 - return_from_interrupt_instr sets global enable
// RULE11 - flag-type source flag cleared by hardware on vectoring
// RULE12 - writing one clears a flag, writing zero leaves it
// RULE13 - events while disabled still set and keep their flag
// RULE14 - level-type source requests only while its condition is present
// RULE15 - one instruction runs after return before any new entry
// RULE16 - status register neither saved nor restored by hardware
// RULE17 - global_disable_instr blocks entry at once, even same cycle
// RULE18 - after global enable instruction, next instruction runs before entry
// RULE19 - entry takes four cycles, pushes pc, then jumps to vector
// RULE20 - running multi-cycle instruction completes before entry starts
// RULE21 - wake from sleep adds four cycles before entry
// RULE22 - return takes four cycles, pops pc, sp plus two, sets global enable; block drives no pc pop or pc load on return, only sp and global enable
// RULE23 - global enable sits in status register bit 7
// RULE24 - entry push decrements stack pointer by two
module cis_seq
  import cis_pkg::*;
#(
  parameter int unsigned            NSRC   = cis_pkg::N_SRC,
  parameter logic [cis_pkg::PC_W-1:0] BOOT = cis_pkg::BOOT_START
) (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_reset,
  input  wire logic [cis_pkg::N_SRC-1:0]   i_src_event,
  input  wire logic [cis_pkg::N_SRC-1:0]   i_src_level,
  input  wire logic                        i_instr_boundary,
  input  wire logic                        i_global_disable_instr,
  input  wire logic                        i_global_enable_instr,
  input  wire logic                        i_return_from_interrupt_instr,
  input  wire logic                        i_sleeping,
  input  wire logic [cis_pkg::PC_W-1:0]    i_pc,
  input  wire logic                        i_boot_reset_fuse,
  input  wire logic                        i_app_lock_bit_b,
  input  wire logic                        i_boot_lock_bit_b,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic                             o_stall,
  output logic                             o_load_pc,
  output logic [cis_pkg::PC_W-1:0]         o_new_pc,
  output logic                             o_push_we,
  output logic [cis_pkg::PC_W-1:0]         o_push_pc,
  output logic [cis_pkg::PC_W-1:0]         o_reset_vector,
  output logic [cis_pkg::SP_W-1:0]         o_sp
);
  //////////////////////////////////////////////////////////////////////
  // state
  cis_state_e               state_ff;
  logic [CNT_W-1:0]         cnt_ff;
  logic [7:0]               cpu_status_register_ff;
  logic [NSRC-1:0]          flag_ff;
  logic [NSRC-1:0]          en_ff;
  logic [NSRC-1:0]          kind_ff;
  logic [7:0]               general_irq_control_reg_ff;
  logic [SP_W-1:0]          sp_ff;
  logic [NSRC-1:0]          ev_s1_ff, ev_s2_ff, ev_s3_ff;
  logic [NSRC-1:0]          lv_s1_ff, lv_s2_ff;
  logic                     hold_ff;      // one-instruction holdoff after sei or return
  logic [$clog2(NSRC)-1:0]  idx_ff;
  logic                     wake_ff;
  logic [PC_W-1:0]          ret_pc_ff;
  logic                     pready_ff;

  logic [NSRC-1:0] ev_rise, req, gated;
  logic            any_req, lock_block, take, wr;
  logic [$clog2(NSRC)-1:0] idx;
  logic [PC_W-1:0] vbase;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers, edge taken only past the second stage
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ev_s1_ff <= '0;
      ev_s2_ff <= '0;
      ev_s3_ff <= '0;
      lv_s1_ff <= '0;
      lv_s2_ff <= '0;
    end else begin
      ev_s1_ff <= i_src_event;
      ev_s2_ff <= ev_s1_ff;
      ev_s3_ff <= ev_s2_ff;
      lv_s1_ff <= i_src_level;
      lv_s2_ff <= lv_s1_ff;
    end
  end
  assign ev_rise = ev_s2_ff & ~ev_s3_ff;

  // request vector: flag-type uses flag, level-type only live level
  assign req   = (flag_ff & ~kind_ff) | (lv_s2_ff & kind_ff); // RULE13 RULE14
  assign gated = req & en_ff & {NSRC{cpu_status_register_ff[GIE_BIT]}};       // RULE5 RULE23

  cis_prio #(.N(NSRC)) u_prio (
    .i_req (gated),
    .o_any (any_req),
    .o_idx (idx)
  );

  // boot lock: app lock blocks while in app code, boot lock while in boot code
  assign lock_block = (i_app_lock_bit_b && (i_pc <  BOOT)) ||
                      (i_boot_lock_bit_b && (i_pc >= BOOT)); // RULE7

  // entry decision at an instruction boundary only
  assign take = (state_ff == CIS_RUN) && i_instr_boundary && any_req && !hold_ff &&
                !i_global_disable_instr && !lock_block; // RULE17 RULE20 RULE15 RULE18

  assign vbase = general_irq_control_reg_ff[GENERAL_IRQ_CONTROL_REG_VSEL] ? BOOT : APP_BASE; // RULE6

  // apb decode
  assign wr = psel && penable && pwrite && pready_ff;
  // reads need no strobe here: read data is latched in the setup cycle below

  //////////////////////////////////////////////////////////////////////
  // sequencer: run, optional wake delay, four-cycle entry, four-cycle return
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_ff  <= CIS_RUN;
      cnt_ff    <= '0;
      idx_ff    <= '0;
      wake_ff   <= 1'b0;
      ret_pc_ff <= '0;
    end else begin
      unique case (state_ff)
        CIS_RUN: begin
          if (take) begin
            idx_ff    <= idx;
            ret_pc_ff <= i_pc;
            wake_ff   <= i_sleeping;
            cnt_ff    <= '0;
            state_ff  <= i_sleeping ? CIS_WAKE : CIS_ENTRY; // RULE21
          end else if (i_return_from_interrupt_instr && i_instr_boundary) begin
            cnt_ff   <= '0;
            state_ff <= CIS_RET; // RULE22
          end
        end
        CIS_WAKE: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == CNT_W'(WAKE_CYC - 1)) begin
            cnt_ff   <= '0;
            state_ff <= CIS_ENTRY; // RULE21
          end
        end
        CIS_ENTRY: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == CNT_W'(ENTRY_CYC - 1)) begin
            cnt_ff   <= '0;
            state_ff <= CIS_RUN; // RULE19
          end
        end
        CIS_RET: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == CNT_W'(RETURN_CYC - 1)) begin
            cnt_ff   <= '0;
            state_ff <= CIS_RUN; // RULE22
          end
        end
        default: state_ff <= CIS_RUN;
      endcase
    end
  end

  // holdoff: one instruction must retire after sei or return
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      hold_ff <= 1'b0;
    end else if (state_ff == CIS_RET && cnt_ff == CNT_W'(RETURN_CYC - 1)) begin
      hold_ff <= 1'b1; // RULE15
    end else if (state_ff == CIS_RUN && i_global_enable_instr && i_instr_boundary) begin
      hold_ff <= 1'b1; // RULE18
    end else if (state_ff == CIS_RUN && i_instr_boundary) begin
      hold_ff <= 1'b0;
    end
  end

  // status register: hardware only touches global enable
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cpu_status_register_ff <= CPU_STATUS_REGISTER_RESET;
    end else begin
      if (wr && paddr == A_STATUS) begin
        cpu_status_register_ff <= pwdata[7:0]; // RULE9
      end
      if (i_global_disable_instr && i_instr_boundary) begin
        cpu_status_register_ff[GIE_BIT] <= 1'b0; // RULE17
      end else if (i_global_enable_instr && i_instr_boundary) begin
        cpu_status_register_ff[GIE_BIT] <= 1'b1;
      end
      if (take) begin
        cpu_status_register_ff[GIE_BIT] <= 1'b0; // RULE8 RULE16
      end else if (state_ff == CIS_RET && cnt_ff == CNT_W'(RETURN_CYC - 1)) begin
        cpu_status_register_ff[GIE_BIT] <= 1'b1; // RULE10 RULE22
      end
    end
  end

  // flags: set by event, cleared by vectoring or write one; set wins
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      flag_ff <= '0;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (ev_rise[i]) begin
          flag_ff[i] <= 1'b1; // RULE13
        end else if (wr && paddr == A_FLAGS && pwdata[i]) begin
          flag_ff[i] <= 1'b0; // RULE12
        end else if (take && idx == ($clog2(NSRC))'(i) && !kind_ff[i]) begin
          flag_ff[i] <= 1'b0; // RULE11
        end
      end
    end
  end

  // software control registers
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      en_ff   <= '0;
      kind_ff <= '0;
      general_irq_control_reg_ff <= '0;
    end else if (wr) begin
      if (paddr == A_ENABLE) en_ff   <= pwdata[NSRC-1:0];
      if (paddr == A_KIND)   kind_ff <= pwdata[NSRC-1:0];
      if (paddr == A_GENERAL_IRQ_CONTROL_REG)   general_irq_control_reg_ff <= pwdata[7:0];
    end
  end

  // stack pointer: down two at push, up two at pop
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sp_ff <= SP_RESET;
    end else if (state_ff == CIS_ENTRY && cnt_ff == '0) begin
      sp_ff <= sp_ff - SP_W'(SP_STEP); // RULE24
    end else if (state_ff == CIS_RET && cnt_ff == '0) begin
      sp_ff <= sp_ff + SP_W'(SP_STEP); // RULE22
    end else if (wr && paddr == A_SP) begin
      sp_ff <= pwdata[SP_W-1:0];
    end
  end

  // sequencer outputs, all registered
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_stall        <= 1'b0;
      o_load_pc      <= 1'b0;
      o_new_pc       <= '0;
      o_push_we      <= 1'b0;
      o_push_pc      <= '0;
      o_reset_vector <= APP_BASE;
      o_sp           <= SP_RESET;
    end else begin
      o_stall   <= take || (state_ff != CIS_RUN &&
                   !(state_ff != CIS_WAKE && cnt_ff == CNT_W'(ENTRY_CYC - 1))); // RULE2
      o_push_we <= (state_ff == CIS_ENTRY && cnt_ff == '0); // RULE19
      o_push_pc <= ret_pc_ff;
      o_load_pc <= (state_ff == CIS_ENTRY && cnt_ff == CNT_W'(ENTRY_CYC - 1));
      o_new_pc  <= vbase + PC_W'(32'(idx_ff + 1) * VEC_STEP); // RULE3 RULE4
      o_reset_vector <= i_boot_reset_fuse ? BOOT : APP_BASE; // RULE6
      o_sp      <= sp_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states, unmapped reads zero with error
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      prdata    <= '0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      pready_ff <= 1'b0;
    end else begin
      pready    <= psel && !penable;
      pready_ff <= psel && !penable;
      pslverr   <= 1'b0;
      prdata    <= '0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          A_STATUS: prdata <= {24'h0000_00, cpu_status_register_ff};
          A_FLAGS:  prdata <= 32'(flag_ff);
          A_ENABLE: prdata <= 32'(en_ff);
          A_GENERAL_IRQ_CONTROL_REG:   prdata <= {24'h0000_00, general_irq_control_reg_ff};
          A_SP:     prdata <= 32'(sp_ff);
          A_SEQ:    prdata <= 32'({wake_ff, idx_ff, state_ff});
          A_KIND:   prdata <= 32'(kind_ff);
          default:  pslverr <= 1'b1;
        endcase
      end else if (psel && !penable) begin
        pslverr <= !(paddr inside {A_STATUS, A_FLAGS, A_ENABLE, A_GENERAL_IRQ_CONTROL_REG, A_SP, A_KIND});
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  a_entry_clears_gie: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    take |=> !cpu_status_register_ff[GIE_BIT]) else $error("gie not cleared on entry"); // RULE8
  a_entry_four_cyc: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (take && !i_sleeping) |=> (state_ff == CIS_ENTRY)[*4] ##1 state_ff == CIS_RUN)
    else $error("entry not four cycles"); // RULE19
  a_wake_extra: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (take && i_sleeping) |=> (state_ff == CIS_WAKE)[*4] ##1 state_ff == CIS_ENTRY)
    else $error("wake delay not four cycles"); // RULE21
  a_ret_sets_gie: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $rose(state_ff == CIS_RET) |-> ##4 cpu_status_register_ff[GIE_BIT]) else $error("return left gie clear"); // RULE10
  a_ret_sp_up: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $rose(state_ff == CIS_RET) |=> sp_ff == $past(sp_ff) + SP_W'(SP_STEP))
    else $error("sp not raised by two"); // RULE22
  a_push_sp_down: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    take && !i_sleeping |=> ##1 sp_ff == $past(sp_ff, 2) - SP_W'(SP_STEP))
    else $error("sp not lowered by two"); // RULE24
  a_disable_blocks: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_global_disable_instr |-> !take) else $error("entry after global disable"); // RULE17
  a_gate_enables: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    take |-> en_ff[idx] && cpu_status_register_ff[GIE_BIT]) else $error("disabled source taken"); // RULE5
  a_flag_cleared: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (take && !kind_ff[idx] && !ev_rise[idx]) |=> !flag_ff[$past(idx)])
    else $error("flag not cleared on vector"); // RULE11
  a_hold_after_ret: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $fell(state_ff == CIS_RET) |-> !take) else $error("entry right after return"); // RULE15
endmodule // cis_seq

// file: rtl/cis_pkg.sv
// cis_pkg: constants for the cpu interrupt sequencer
// assumes: one 100 MHz cpu clock, no divider in front of it
package cis_pkg;
  localparam int unsigned N_SRC        = 8;                 // interrupt sources, index 0 ranks first
  localparam int unsigned PC_W         = 12;                // program counter width
  localparam int unsigned SP_W         = 16;                // stack pointer width
  localparam int unsigned VEC_STEP     = 1;                 // words between vectors
  localparam int unsigned ENTRY_CYC    = 4;                 // entry response cycles
  localparam int unsigned WAKE_CYC     = 4;                 // added cycles when woken from sleep
  localparam int unsigned RETURN_CYC   = 4;                 // return sequence cycles
  localparam int unsigned SP_STEP      = 2;                 // bytes per return address
  localparam int unsigned GIE_BIT      = 7;                 // global enable in status register
  localparam int unsigned CNT_W        = 4;                 // sequence counter width
  localparam logic [PC_W-1:0] BOOT_START = 12'h0_C00;       // default start of boot section
  localparam logic [PC_W-1:0] APP_BASE   = 12'h0_000;       // default vector base
  localparam logic [SP_W-1:0] SP_RESET   = 16'h0_000;
  localparam logic [7:0]      CPU_STATUS_REGISTER_RESET = 8'h0_0;
  // apb register map
  localparam logic [7:0] A_STATUS   = 8'h0_0;  // cpu_status_register, bit 7 global enable
  localparam logic [7:0] A_FLAGS    = 8'h0_4;  // flag-type pending bits, write one clears
  localparam logic [7:0] A_ENABLE   = 8'h0_8;  // per source enable
  localparam logic [7:0] A_GENERAL_IRQ_CONTROL_REG     = 8'h0_C;  // general_irq_control_reg
  localparam logic [7:0] A_SP       = 8'h1_0;  // stack pointer
  localparam logic [7:0] A_SEQ      = 8'h1_4;  // read only sequencer state
  localparam logic [7:0] A_KIND     = 8'h1_8;  // 1 = level-type source
  localparam int unsigned GENERAL_IRQ_CONTROL_REG_VSEL = 1;       // vector_relocate_select bit position
  typedef enum logic [2:0] {
    CIS_RUN   = 3'b000,
    CIS_WAKE  = 3'b001,
    CIS_ENTRY = 3'b010,
    CIS_RET   = 3'b011,
    CIS_HOLD  = 3'b100
  } cis_state_e;
endpackage : cis_pkg

// file: rtl/cis_prio.sv
// cis_prio: fixed priority pick, lowest index (lowest vector) wins
// assumes: combinational, same clock domain as its user
`timescale 1ns/1ps
module cis_prio #(
  parameter int unsigned N = 8
) (
  input  wire logic [N-1:0]         i_req,
  output logic                      o_any,
  output logic [$clog2(N)-1:0]      o_idx
);
  // scan from top so the lowest index is the last to land
  always_comb begin
    o_any = 1'b0;
    o_idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (i_req[i]) begin
        o_any = 1'b1;
        o_idx = ($clog2(N))'(i);
      end
    end
  end
endmodule // cis_prio

// file: bench/cis_cpu_model.sv
// cis_cpu_model: behavioural program sequencer facing the interrupt sequencer
// assumes: single-cycle instructions, core halts while i_stall is high
`timescale 1ns/1ps
module cis_cpu_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic       i_stall,
  input  wire logic       i_push_we,
  input  wire logic       i_load_pc,
  input  wire logic [1:0] i_kind,
  output logic            o_boundary,
  output logic            o_dis,
  output logic            o_en,
  output logic            o_ret,
  output logic            o_done,
  output logic [3:0]      o_gap
);
  logic [3:0] gap_cnt_ff;
  //////////////////////////////////////////////////////////////////////////
  // one instruction per free cycle, special strobes only with a boundary
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_boundary <= 1'b0;
      o_dis      <= 1'b0;
      o_en       <= 1'b0;
      o_ret      <= 1'b0;
      o_done     <= 1'b0;
    end else begin
      o_boundary <= !i_stall;  // no instruction ends while held
      o_dis      <= !i_stall && !o_done && i_kind == 2'd1;
      o_en       <= !i_stall && !o_done && i_kind == 2'd2;
      o_ret      <= !i_stall && !o_done && i_kind == 2'd3;
      o_done     <= !i_stall && !o_done && i_kind != 2'd0;
    end
  end
  // cycles from the push strobe to the vector load
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      gap_cnt_ff <= 4'h0;
      o_gap      <= 4'h0;
    end else begin
      gap_cnt_ff <= i_push_we ? 4'h1 : gap_cnt_ff + 4'h1;
      if (i_load_pc) begin
        o_gap <= gap_cnt_ff;
      end
    end
  end
endmodule // cis_cpu_model

// file: bench/cpu_interrupt_sequencer_test.sv
// cpu_interrupt_sequencer_test: directed checks of cis_seq over apb and core strobes
// assumes: cis_cpu_model plays the program sequencer, bench drives events and levels
`timescale 1ns/1ps
module cpu_interrupt_sequencer_test;
  import cis_pkg::*;
  logic             i_sys_clk, i_reset, psel, penable, pwrite, pready, pslverr, rerr, seen;
  logic             boundary, dis, en, ret, done, sleeping, fuse, app_lock, boot_lock, stall, load_pc, push_we;
  logic [N_SRC-1:0] src_event, src_level;
  logic [PC_W-1:0]  pc, new_pc, reset_vector, vec, push_pc;
  logic [SP_W-1:0]  sp;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rdat;
  logic [3:0]       gap;
  logic [1:0]       kind;
  int               failures, num_checks, lat;
  //////////////////////////////////////////////////////////////////////////
  // clock and instances
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  cis_seq u_cis_seq (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_src_event(src_event), .i_src_level(src_level),
    .i_instr_boundary(boundary), .i_global_disable_instr(dis), .i_global_enable_instr(en),
    .i_return_from_interrupt_instr(ret), .i_sleeping(sleeping), .i_pc(pc), .i_boot_reset_fuse(fuse),
    .i_app_lock_bit_b(app_lock), .i_boot_lock_bit_b(boot_lock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .o_stall(stall), .o_load_pc(load_pc), .o_new_pc(new_pc), .o_push_we(push_we),
    .o_push_pc(push_pc), .o_reset_vector(reset_vector), .o_sp(sp));
  cis_cpu_model u_cis_cpu_model (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_stall(stall), .i_push_we(push_we),
    .i_load_pc(load_pc), .i_kind(kind), .o_boundary(boundary), .o_dis(dis), .o_en(en),
    .o_ret(ret), .o_done(done), .o_gap(gap));
  //////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hung access
    do begin
      @(posedge i_sys_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask
  task automatic fire(input logic [7:0] m);
    src_event <= m;
    repeat (4) @(posedge i_sys_clk);
    src_event <= '0;
  endtask
  task automatic watch(input int n, input logic exp_seen, input logic [PC_W-1:0] exp_vec);
    seen = 1'b0;
    vec = '0;
    lat = 0;
    repeat (n) begin
      @(posedge i_sys_clk);
      if (stall === 1'b1 && !seen) lat++;  // held cycles up to the vector load
      if (load_pc === 1'b1 && !seen) begin
        seen = 1'b1;
        vec = new_pc;
      end
    end
    chk(32'(seen), 32'(exp_seen));
    chk(32'(vec), 32'(exp_vec));
  endtask
  task automatic issue(input logic [1:0] k);
    kind <= k;
    do begin
      @(posedge i_sys_clk);
    end while (done !== 1'b1);
    kind <= 2'd0;
  endtask
  task automatic do_return;
    issue(2'd3);
    repeat (10) @(posedge i_sys_clk);
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    rd(A_STATUS, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    chk(32'(rerr), 32'h0000_0001);
    chk(32'(reset_vector), 32'h0000_0000);
  endtask
  task automatic t_pending;
    apb(1'b1, A_SP, 32'h0000_0100);
    apb(1'b1, A_ENABLE, 32'h0000_0004);
    apb(1'b1, A_STATUS, 32'h0000_0005);
    fire(8'h04);
    watch(30, 1'b0, '0);
    rd(A_FLAGS, 32'h0000_0004);
    apb(1'b1, A_FLAGS, 32'h0000_0000);
    rd(A_FLAGS, 32'h0000_0004);
    apb(1'b1, A_STATUS, 32'h0000_0085);
    watch(40, 1'b1, 12'h003);
    chk(32'(gap), 32'h0000_0003);
    chk(32'(lat), 32'(ENTRY_CYC));
    chk(32'(sp), 32'h0000_00FE);
    rd(A_STATUS, 32'h0000_0005);
    rd(A_SP, 32'h0000_00FE);
    rd(A_FLAGS, 32'h0000_0000);
    apb(1'b1, A_STATUS, 32'h0000_0003);
    do_return();
    rd(A_STATUS, 32'h0000_0083);
    rd(A_SP, 32'h0000_0100);
  endtask
  task automatic t_prio;
    apb(1'b1, A_ENABLE, 32'h0000_0009);
    fire(8'h09);
    watch(40, 1'b1, 12'h001);
    rd(A_FLAGS, 32'h0000_0008);
    apb(1'b1, A_FLAGS, 32'h0000_0008);
    rd(A_FLAGS, 32'h0000_0000);
    do_return();
  endtask
  task automatic t_reloc;
    apb(1'b1, A_GENERAL_IRQ_CONTROL_REG, 32'h0000_0002);
    apb(1'b1, A_ENABLE, 32'h0000_0020);
    fire(8'h20);
    watch(40, 1'b1, BOOT_START + 12'h006);
    fuse <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    chk(32'(reset_vector), 32'(BOOT_START));
    do_return();
    fuse <= 1'b0;
    apb(1'b1, A_GENERAL_IRQ_CONTROL_REG, 32'h0000_0000);
  endtask
  task automatic t_cli;
    apb(1'b1, A_ENABLE, 32'h0000_0010);
    issue(2'd1);
    fire(8'h10);
    watch(30, 1'b0, '0);
    rd(A_STATUS, 32'h0000_0003);
    apb(1'b1, A_FLAGS, 32'h0000_0010);
  endtask
  task automatic t_level;
    apb(1'b1, A_KIND, 32'h0000_0040);
    apb(1'b1, A_ENABLE, 32'h0000_0040);
    src_level <= 8'h40;
    repeat (8) @(posedge i_sys_clk);
    src_level <= 8'h00;
    issue(2'd2);
    watch(30, 1'b0, '0);
    src_level <= 8'h40;
    watch(40, 1'b1, 12'h007);
    src_level <= 8'h00;
    do_return();
  endtask
  task automatic t_sleep;
    apb(1'b1, A_ENABLE, 32'h0000_0004);
    sleeping <= 1'b1;
    fire(8'h04);
    watch(40, 1'b1, 12'h003);
    chk(32'(gap), 32'h0000_0003);
    chk(32'(lat), 32'(ENTRY_CYC + WAKE_CYC));
    sleeping <= 1'b0;
    do_return();
  endtask
  task automatic t_lock;
    app_lock <= 1'b1;
    pc <= 12'h010;
    apb(1'b1, A_ENABLE, 32'h0000_0002);
    fire(8'h02);
    watch(30, 1'b0, '0);
    pc <= 12'hC10;
    watch(40, 1'b1, 12'h002);
    chk(32'(push_pc), 32'h0000_0C10);
    do_return();
    app_lock <= 1'b0;
    boot_lock <= 1'b1;
    fire(8'h02);
    watch(30, 1'b0, '0);
    pc <= 12'h010;
    watch(40, 1'b1, 12'h002);
    do_return();
    boot_lock <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    {psel, penable, pwrite, sleeping, fuse, app_lock, boot_lock} = '0;
    {paddr, pwdata, src_event, src_level, pc, kind} = '0;
    failures = 0;
    num_checks = 0;
    i_reset = 1'b1;
    repeat (10) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    t_regs();
    t_pending();
    t_prio();
    t_reloc();
    t_cli();
    t_level();
    t_sleep();
    t_lock();
    summarize();
  end
  initial begin
    #300000;
    failures++;
    summarize();
  end
endmodule // cpu_interrupt_sequencer_test
